// ---- hdl/cwod_decoder.sv ----
/*
  configuration word option decoder with the reset-option sequencer.
  holds the configuration word, writable only in programming operation,
  decodes its fields and sequences brown-out, power-up delay, oscillator
  start-up and sleep. assumes power_on_n, brownout_n, prog_mode, mclr_n,
  osc_input_pin, watchdog_wake and irq_wake are asynchronous pins.
*/
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

module cwod_decoder
  import cwod_pkg::*;
#(
  parameter int PWRUP_CYCLES = CWOD_PWRUP_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        power_on_n,
  input  wire logic        brownout_n,
  input  wire logic        mclr_n,
  input  wire logic        prog_mode,
  input  wire logic [13:0] addr,
  input  wire logic [13:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [13:0] rdata,
  input  wire logic        osc_input_pin,
  input  wire logic        watchdog_wake,
  input  wire logic        irq_wake,
  input  wire logic        sleep_req,
  output logic      [1:0]  osc_mode,
  output logic             low_power_crystal_mode,
  output logic             crystal_resonator_mode,
  output logic             high_speed_crystal_mode,
  output logic             rc_osc_mode,
  output logic             brownout_detect_en,
  output logic             powerup_delay_en,
  output logic             watchdog_en,
  output logic      [1:0]  protect_level,
  output logic             protect_agree,
  output logic             device_reset,
  output logic             asleep
);

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic por_n_s;
  logic bo_n_s;
  logic mclr_n_s;
  logic prog_s;
  logic osc_s;
  logic wdw_s;
  logic irq_s;

  localparam int NPIN = 7;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_syn;

  assign pin_raw = {power_on_n, brownout_n, mclr_n, prog_mode,
                    osc_input_pin, watchdog_wake, irq_wake};

  generate
    for (genvar i = 0; i < NPIN; i++) begin : g_sync
      cwod_sync u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in (pin_raw[i]),
        .sync_out (pin_syn[i])
      );
    end
  endgenerate

  assign {por_n_s, bo_n_s, mclr_n_s, prog_s, osc_s, wdw_s, irq_s} = pin_syn;

  ////////////////////////////////////////////////////////////////////////////////
  // configuration word storage

  function automatic logic in_test_space(input logic [13:0] a);
    in_test_space = (a >= CWOD_TEST_SPACE_LO) && (a <= CWOD_TEST_SPACE_HI);
  endfunction

  logic [13:0] cfg_word;
  logic        hit_cfg;
  logic        wr_cfg;
  logic        rd_ok;
  logic [13:0] cfg_view;
  logic [13:0] next_rdata;

  // only the single location is stored; the rest of the test space reads erased
  assign hit_cfg = (addr == CWOD_CFG_ADDR);
  assign rd_ok   = prog_s && in_test_space(addr);
  assign wr_cfg  = wr && prog_s && hit_cfg;
  // bit 7 is stored but not decoded, and reads one in programming mode
  assign cfg_view = cfg_word | (14'h0001 << CWOD_UNUSED_BIT);
  assign next_rdata = !rd ? rdata :
                      !rd_ok ? 14'h0000 :
                      hit_cfg ? cfg_view : CWOD_CFG_ERASED;

  // eprom semantics: writing a 0 programs a bit; only erase (reset) returns it to 1
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_word <= CWOD_CFG_ERASED;
    end else if (wr_cfg) begin
      cfg_word <= cfg_word & wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 14'h0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // field decode

  function automatic logic [1:0] cp_pair(input logic [13:0] w, input int lo);
    cp_pair = w[lo +: 2];
  endfunction

  logic [1:0] next_osc;
  logic       next_bo_en;
  logic       next_pd_en;
  logic       next_wd_en;
  logic [1:0] cp0;
  logic [1:0] cp1;
  logic [1:0] cp2;
  logic [1:0] cp3;
  logic       cp_same;
  logic       crystal;

  assign next_osc   = {cfg_word[CWOD_OSC_HI_BIT], cfg_word[CWOD_OSC_LO_BIT]};
  assign next_bo_en = cfg_word[CWOD_BROWNOUT_BIT];
  // brown-out enable overrides the active-low power-up bit
  assign next_pd_en = !cfg_word[CWOD_PWRUP_N_BIT] || next_bo_en;
  assign next_wd_en = cfg_word[CWOD_WATCHDOG_BIT];
  assign cp0 = cp_pair(cfg_word, CWOD_CP_PAIR0_LO);
  assign cp1 = cp_pair(cfg_word, CWOD_CP_PAIR1_LO);
  assign cp2 = cp_pair(cfg_word, CWOD_CP_PAIR2_LO);
  assign cp3 = cp_pair(cfg_word, CWOD_CP_PAIR3_LO);
  // mismatched copies are a programmer fault; protect fully rather than guess
  assign cp_same = (cp0 == cp1) && (cp1 == cp2) && (cp2 == cp3);
  assign crystal = (next_osc != CWOD_OSC_RC);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_mode                <= CWOD_OSC_RC;
      low_power_crystal_mode  <= 1'b0;
      crystal_resonator_mode  <= 1'b0;
      high_speed_crystal_mode <= 1'b0;
      rc_osc_mode             <= 1'b1;
      brownout_detect_en      <= 1'b1;
      powerup_delay_en        <= 1'b1;
      watchdog_en             <= 1'b1;
      protect_level           <= CWOD_CP_OFF;
      protect_agree           <= 1'b1;
    end else begin
      osc_mode                <= next_osc;
      low_power_crystal_mode  <= (next_osc == CWOD_OSC_LP);
      crystal_resonator_mode  <= (next_osc == CWOD_OSC_XT);
      high_speed_crystal_mode <= (next_osc == CWOD_OSC_HS);
      rc_osc_mode             <= (next_osc == CWOD_OSC_RC);
      brownout_detect_en      <= next_bo_en;
      powerup_delay_en        <= next_pd_en;
      watchdog_en             <= next_wd_en;
      protect_level           <= cp_same ? cp0 : 2'h0;
      protect_agree           <= cp_same;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reset sequencer

  cwod_state_e state;
  cwod_state_e next_state;
  logic        osc_q;
  logic        osc_rise;
  logic        bo_hit;
  logic        pd_load;
  logic        pd_done;
  logic        ost_load;
  logic        ost_done;
  logic        wake;
  logic        por_cause;
  logic [CWOD_DLY_W-1:0] pd_len;

  // external clock or crystal both arrive as edges on the same pin
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      osc_q <= 1'b0;
    end else begin
      osc_q <= osc_s;
    end
  end
  assign osc_rise = osc_s && !osc_q;

  // only a power-on start or a crystal wake from sleep runs the start-up counter; a brown-out restart skips it,
  // since the oscillator kept running through the dip
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      por_cause <= 1'b1;
    end else if (!por_n_s) begin
      por_cause <= 1'b1;
    end else if (state == CWOD_ST_RUN) begin
      por_cause <= 1'b0;
    end
  end

  assign bo_hit  = next_bo_en && !bo_n_s;
  assign wake    = !mclr_n_s || wdw_s || irq_s;
  // brown-out restarts the delay on every dip
  assign pd_load = !por_n_s || bo_hit;
  assign pd_len  = next_pd_en ? CWOD_DLY_W'(PWRUP_CYCLES) : '0;
  assign ost_load = (state != CWOD_ST_OSTART) && (next_state == CWOD_ST_OSTART);

  cwod_delay_cnt #(.W(CWOD_DLY_W)) u_pwrup (
    .clk      (clk),
    .rst_n    (rst_n),
    .load     (pd_load),
    .load_val (pd_len),
    .dec      (state == CWOD_ST_PWRUP),
    .done     (pd_done)
  );

  cwod_delay_cnt #(.W(CWOD_OST_W)) u_ostart (
    .clk      (clk),
    .rst_n    (rst_n),
    .load     (ost_load),
    .load_val (CWOD_OST_W'(CWOD_OSC_START_EDGES - 1)),
    .dec      (osc_rise),
    .done     (ost_done)
  );

  always_comb begin
    next_state = state;
    case (state)
      CWOD_ST_BROWNOUT: begin
        if (por_n_s && !bo_hit) begin
          next_state = CWOD_ST_PWRUP;
        end
      end
      CWOD_ST_PWRUP: begin
        if (pd_done) begin
          next_state = (crystal && por_cause) ? CWOD_ST_OSTART : CWOD_ST_RUN;
        end
      end
      CWOD_ST_OSTART: begin
        if (ost_done && osc_rise) begin
          next_state = CWOD_ST_RUN;
        end
      end
      CWOD_ST_RUN: begin
        if (sleep_req) begin
          next_state = CWOD_ST_SLEEP;
        end
      end
      CWOD_ST_SLEEP: begin
        if (wake) begin
          next_state = crystal ? CWOD_ST_OSTART : CWOD_ST_RUN;
        end
      end
      default: begin
        next_state = CWOD_ST_BROWNOUT;
      end
    endcase
    // power-on and brown-out win over everything
    if (!por_n_s || bo_hit) begin
      next_state = CWOD_ST_BROWNOUT;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state        <= CWOD_ST_BROWNOUT;
      device_reset <= 1'b1;
      asleep       <= 1'b0;
    end else begin
      state        <= next_state;
      device_reset <= (next_state != CWOD_ST_RUN) && (next_state != CWOD_ST_SLEEP);
      asleep       <= (next_state == CWOD_ST_SLEEP);
    end
  end

endmodule // cwod_decoder

// ---- hdl/cwod_delay_cnt.sv ----
/*
  load-and-count-down delay counter; done is high while the count is zero.
  assumes load and dec come from logic on clk.
*/
`timescale 1ns/1ps
module cwod_delay_cnt #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         dec,
  output logic              done
);
  logic [W-1:0] count;

  assign done = (count == '0);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= '0;
    end else if (load) begin
      count <= load_val;
    end else if (dec && !done) begin
      count <= count - W'(1);
    end
  end
endmodule // cwod_delay_cnt

// ---- hdl/cwod_pkg.sv ----
/*
  package of constants for the configuration word option decoder.
  assumes a 100 MHz clock; every counter in the block runs on it.
*/
package cwod_pkg;

  localparam logic [13:0] CWOD_CFG_ADDR       = 14'h2007;
  localparam logic [13:0] CWOD_TEST_SPACE_LO  = 14'h2000;
  localparam logic [13:0] CWOD_TEST_SPACE_HI  = 14'h3fff;
  localparam logic [13:0] CWOD_CFG_ERASED     = 14'h3fff;

  // bit positions inside the configuration word
  localparam int CWOD_OSC_LO_BIT      = 0;
  localparam int CWOD_OSC_HI_BIT      = 1;
  localparam int CWOD_WATCHDOG_BIT    = 2;
  localparam int CWOD_PWRUP_N_BIT     = 3;
  localparam int CWOD_CP_PAIR0_LO     = 4;
  localparam int CWOD_BROWNOUT_BIT    = 6;
  localparam int CWOD_UNUSED_BIT      = 7;
  localparam int CWOD_CP_PAIR1_LO     = 8;
  localparam int CWOD_CP_PAIR2_LO     = 10;
  localparam int CWOD_CP_PAIR3_LO     = 12;

  localparam logic [1:0] CWOD_OSC_RC = 2'h3;
  localparam logic [1:0] CWOD_OSC_HS = 2'h2;
  localparam logic [1:0] CWOD_OSC_XT = 2'h1;
  localparam logic [1:0] CWOD_OSC_LP = 2'h0;
  localparam logic [1:0] CWOD_CP_OFF = 2'h3;

  // timing
  localparam int CWOD_CLK_PERIOD_NS   = 10;
  localparam int CWOD_PWRUP_DELAY_MS  = 72;
  localparam int CWOD_PWRUP_CYCLES    = (CWOD_PWRUP_DELAY_MS * 1000000) / CWOD_CLK_PERIOD_NS;
  localparam int CWOD_OSC_START_EDGES = 1024;
  localparam int CWOD_DLY_W           = 23;
  localparam int CWOD_OST_W           = 11;

  typedef enum logic [4:0] {
    CWOD_ST_BROWNOUT = 5'h01,
    CWOD_ST_PWRUP    = 5'h02,
    CWOD_ST_OSTART   = 5'h04,
    CWOD_ST_RUN      = 5'h08,
    CWOD_ST_SLEEP    = 5'h10
  } cwod_state_e;

endpackage

// ---- hdl/cwod_sync.sv ----
/*
  two flip-flop synchroniser for a single level.
  assumes the input is asynchronous to clk.
*/
`timescale 1ns/1ps
module cwod_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta;

  // meta feeds only the second stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta     <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule // cwod_sync

// ---- test/cwod_prog_model.sv ----
/* programmer model driving the strobed configuration access port.
   assumes read data stand from the cycle after the read strobe and hold until the next read. */
`timescale 1ns/1ps
module cwod_prog_model (
  input  wire logic        clk,
  input  wire logic [13:0] rdata,
  output logic             prog_mode,
  output logic [13:0]      addr,
  output logic [13:0]      wdata,
  output logic             wr,
  output logic             rd
);
  ////////////////////////////////////////
  initial begin
    prog_mode = 1'b0;
    addr = 14'h0000;
    wdata = 14'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  // waits out the pin synchroniser before any access
  task automatic set_prog(input logic on);
    @(posedge clk);
    prog_mode <= on;
    repeat (3) @(posedge clk);
  endtask
  // released lines show the inverse so a stale value cannot pass
  task automatic write_word(input logic [13:0] a, input logic [13:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic read_word(input logic [13:0] a, output logic [13:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    @(negedge clk);
    d = rdata;
  endtask
endmodule // cwod_prog_model

// ---- test/cwod_properties.sv ----
/* port checker for the option decoder, bound into cwod_decoder.
   assumes one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
module cwod_properties
  import cwod_pkg::*;
#(
  parameter int PWRUP_CYCLES = 20
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        power_on_n,
  input wire logic        brownout_n,
  input wire logic        prog_mode,
  input wire logic [13:0] addr,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [13:0] rdata,
  input wire logic        irq_wake,
  input wire logic [1:0]  osc_mode,
  input wire logic        brownout_detect_en,
  input wire logic        powerup_delay_en,
  input wire logic        watchdog_en,
  input wire logic [1:0]  protect_level,
  input wire logic        protect_agree,
  input wire logic        device_reset,
  input wire logic        asleep
);
  ////////////////////////////////////////
  logic [31:0] since_cause;
  logic [2:0]  prog_hist;
  logic        prog_quiet;
  logic        prog_steady;
  logic [6:0]  opts;
  // the pin passes two flops before the design acts, so judge it on a steady history
  assign prog_quiet  = ~|{prog_hist, prog_mode};
  assign prog_steady = &{prog_hist, prog_mode};
  assign opts = {osc_mode, brownout_detect_en, powerup_delay_en, watchdog_en, protect_level};
  always_ff @(posedge clk) begin
    prog_hist <= {prog_hist[1:0], prog_mode};
    if (!rst_n || !power_on_n || (brownout_detect_en && !brownout_n)) begin
      since_cause <= 32'h0;
    end else if (since_cause != 32'hffffffff) begin
      since_cause <= since_cause + 32'h1;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  a_erased_decode: assert property ($rose(rst_n) |-> osc_mode == CWOD_OSC_RC
    && brownout_detect_en && watchdog_en && protect_agree && protect_level == CWOD_CP_OFF
    && device_reset && !asleep) else $error("erased decode wrong");
  a_pd_forced: assert property (brownout_detect_en |-> powerup_delay_en)
    else $error("power-up delay not forced");
  a_cp_disagree: assert property (!protect_agree |-> protect_level == 2'h0)
    else $error("disagreeing copies not fully protected");
  a_foreign_addr: assert property (wr && addr != CWOD_CFG_ADDR |=> ##1 $stable(opts))
    else $error("write elsewhere changed options");
  a_locked_write: assert property (wr && prog_quiet |=> ##1 $stable(opts))
    else $error("write outside programming took effect");
  a_read_refused: assert property (rd && prog_quiet |=> rdata == 14'h0000)
    else $error("read outside programming not zero");
  a_read_bit7:
    assert property (rd && prog_steady && addr >= CWOD_TEST_SPACE_LO |=> rdata[7])
    else $error("unused bit not one");
  a_pwrup_hold:
    assert property ($fell(device_reset) && powerup_delay_en |-> since_cause >= PWRUP_CYCLES)
    else $error("reset released early");
  a_rise_cause:
    assert property ($rose(device_reset) && !$past(asleep) |-> since_cause < 32'h6)
    else $error("reset without enabled cause");
  a_wake_irq: assert property (asleep && irq_wake |-> ##[1:6] !asleep)
    else $error("no wake on interrupt");
endmodule // cwod_properties

bind cwod_decoder cwod_properties #(.PWRUP_CYCLES(PWRUP_CYCLES)) u_props (
  .clk                (clk),
  .rst_n              (rst_n),
  .power_on_n         (power_on_n),
  .brownout_n         (brownout_n),
  .prog_mode          (prog_mode),
  .addr               (addr),
  .wr                 (wr),
  .rd                 (rd),
  .rdata              (rdata),
  .irq_wake           (irq_wake),
  .osc_mode           (osc_mode),
  .brownout_detect_en (brownout_detect_en),
  .powerup_delay_en   (powerup_delay_en),
  .watchdog_en        (watchdog_en),
  .protect_level      (protect_level),
  .protect_agree      (protect_agree),
  .device_reset       (device_reset),
  .asleep             (asleep)
);

// ---- test/test_config_word_option_decode.sv ----
/* bench for the option decoder: programmer model plus pin stimulus.
   assumes the checker is bound in and the power-up count is shortened. */
`timescale 1ns/1ps
module test_config_word_option_decode
  import cwod_pkg::*;
;
  localparam int PW = 20;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        power_on_n = 1'b0;
  logic        brownout_n = 1'b1;
  logic        mclr_n = 1'b1;
  logic        osc_input_pin = 1'b0;
  logic        watchdog_wake = 1'b0;
  logic        irq_wake = 1'b0;
  logic        sleep_req = 1'b0;
  logic        prog_mode, wr, rd, brownout_detect_en, powerup_delay_en, watchdog_en;
  logic        low_power_crystal_mode, crystal_resonator_mode, high_speed_crystal_mode;
  logic        rc_osc_mode, protect_agree, device_reset, asleep;
  logic [13:0] addr, wdata, rdata, got;
  logic [1:0]  osc_mode, protect_level;
  int          bad_count = 0;
  int          checks_done = 0;
  int          need;
  // last word gives the protection copies different values on purpose
  logic [13:0] words [4] = '{14'h3fff, 14'h008a, 14'h1595, 14'h3e78};
  wire  [11:0] decode = {rc_osc_mode, high_speed_crystal_mode, crystal_resonator_mode,
    low_power_crystal_mode, osc_mode, brownout_detect_en, powerup_delay_en, watchdog_en,
    protect_level, protect_agree};
  ////////////////////////////////////////
  cwod_decoder #(.PWRUP_CYCLES(PW)) dut (.clk, .rst_n, .power_on_n, .brownout_n, .mclr_n,
    .prog_mode, .addr, .wdata, .wr, .rd, .rdata, .osc_input_pin, .watchdog_wake, .irq_wake,
    .sleep_req, .osc_mode, .low_power_crystal_mode, .crystal_resonator_mode,
    .high_speed_crystal_mode, .rc_osc_mode, .brownout_detect_en, .powerup_delay_en,
    .watchdog_en, .protect_level, .protect_agree, .device_reset, .asleep);
  cwod_prog_model prog (.clk, .rdata, .prog_mode, .addr, .wdata, .wr, .rd);
  always #5 clk = ~clk;
  // free-running external clock so the start-up count has edges
  always #20 osc_input_pin = ~osc_input_pin;
  function automatic logic [11:0] expect_decode(input logic [13:0] w);
    logic agree;
    agree = w[13:12] == w[5:4] && w[11:10] == w[5:4] && w[9:8] == w[5:4];
    return {4'h1 << w[1:0], w[1:0], w[6], w[6] | ~w[3], w[2], agree ? w[5:4] : 2'h0, agree};
  endfunction
  task automatic check_word(input logic [13:0] g, input logic [13:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic check_span(input int g, input int lo, input int hi);
    checks_done++;
    if (g < lo || g > hi) begin
      bad_count++;
      $display("mismatch at %0t: span %0d outside %0d..%0d", $time, g, lo, hi);
    end
  endtask
  task automatic wait_run(input int lo, input int hi);
    int n = 0;
    @(negedge clk);
    while (device_reset === 1'b1 && n < 9000) begin
      @(negedge clk);
      n++;
    end
    check_span(n, lo, hi);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #500us;
    bad_count++;
    stop_test();
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      rst_n <= 1'b0;
      power_on_n <= 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      check_word({2'h0, decode}, {2'h0, expect_decode(CWOD_CFG_ERASED)});
      prog.set_prog(1'b1);
      prog.read_word(CWOD_CFG_ADDR, got);
      check_word(got, CWOD_CFG_ERASED);
      prog.read_word(14'h1fff, got);
      check_word(got, 14'h0000);
      prog.write_word(14'h2006, 14'h0000);
      prog.write_word(CWOD_CFG_ADDR, words[i]);
      prog.read_word(CWOD_CFG_ADDR, got);
      check_word(got, words[i] | 14'h0080);
      check_word({2'h0, decode}, {2'h0, expect_decode(words[i])});
      prog.set_prog(1'b0);
      prog.write_word(CWOD_CFG_ADDR, 14'h0000);
      prog.read_word(CWOD_CFG_ADDR, got);
      check_word(got, 14'h0000);
      check_word({2'h0, decode}, {2'h0, expect_decode(words[i])});
      need = (words[i][6] || !words[i][3]) ? PW : 0;
      // the external clock has a 40 ns period, four clocks per counted edge
      need += (words[i][1:0] != CWOD_OSC_RC) ? CWOD_OSC_START_EDGES * 4 : 0;
      @(posedge clk);
      power_on_n <= 1'b1;
      wait_run(need, need + 24);
      @(posedge clk);
      brownout_n <= 1'b0;
      repeat (4) @(posedge clk);
      brownout_n <= 1'b1;
      repeat (2) @(negedge clk);
      check_word({13'h0, device_reset}, {13'h0, words[i][6]});
      if (words[i][6]) begin
        wait_run(PW, PW + 24);
      end
      for (int j = 0; j < 3 && i == 0; j++) begin
        @(posedge clk);
        sleep_req <= 1'b1;
        @(posedge clk);
        sleep_req <= 1'b0;
        @(negedge clk);
        check_word({13'h0, asleep}, 14'h0001);
        @(posedge clk);
        {irq_wake, watchdog_wake, mclr_n} <= (3'h4 >> j) ^ 3'h1;
        repeat (6) @(negedge clk);
        check_word({13'h0, asleep}, 14'h0000);
        @(posedge clk);
        {irq_wake, watchdog_wake, mclr_n} <= 3'h1;
        repeat (4) @(posedge clk);
      end
    end
    stop_test();
  end
endmodule // test_config_word_option_decode
